/* sim/ocfr_afe_model.sv */
// Amplifier stand-in that finishes each requested calibration after a fixed wait
`timescale 1ns/1ps
`default_nettype none
module ocfr_afe_model #(
   parameter int DLY = 20
) (
   input  wire logic       mclk_in,
   input  wire logic [3:0] start_in,
   output logic [3:0]      done_out
);
   int         cnt [4] = '{default: 0};
   logic [3:0] done_r = 4'h0;
   assign done_out = done_r;
   always @(negedge mclk_in) begin
      for (int i = 0; i < 4; i++) begin
         done_r[i] <= start_in[i] && cnt[i] == DLY;
         cnt[i] <= !start_in[i] ? 0 : (cnt[i] <= DLY ? cnt[i] + 1 : cnt[i]);
      end
   end
endmodule
`default_nettype wire

/* sim/ocfr_chk.sv */
// Checker of register writes, calibration and fault response at the top ports
`timescale 1ns/1ps
`default_nettype none
module ocfr_chk (
   input wire logic        mclk_in,
   input wire logic        nrst_in,
   input wire logic        reg_wr_in,
   input wire logic [3:0]  reg_addr_in,
   input wire logic [11:0] reg_wdata_in,
   input wire logic [5:0]  ds_over_in,
   input wire logic        cal_a_done_in,
   input wire logic [3:0]  drain_source_threshold_code_out,
   input wire logic [2:0]  shunt_overcurrent_threshold_out,
   input wire logic        back_emf_sense_enable_out,
   input wire logic        cal_a_start_out,
   input wire logic        cal_c_start_out,
   input wire logic        cal_bemf_start_out,
   input wire logic        drain_source_overcurrent_flag_out,
   input wire logic        shunt_overcurrent_flag_out,
   input wire logic        fault_output_pin_n_out,
   input wire logic        gate_disable_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   logic [3:0] mode_r;
   logic [7:0] run_r;
   wire logic  ds_f = drain_source_overcurrent_flag_out;
   wire logic  sh_f = shunt_overcurrent_flag_out;
   wire logic  wr_p = reg_wr_in && reg_addr_in == ocfr_pkg::ADDR_PROT;
   wire logic  wr_s = reg_wr_in && reg_addr_in == ocfr_pkg::ADDR_SENSE;
   wire logic  act  = (ds_f && mode_r[3:2] != 2'h3) || (sh_f && mode_r[1:0] != 2'h3);
   // Own copy of both modes, so pin checks do not lean on design state
   always_ff @(posedge mclk_in) begin
      if (!nrst_in)
         mode_r <= 4'h0;
      else if (wr_p)
         mode_r <= {reg_wdata_in[11:10], reg_wdata_in[1:0]};
      run_r <= (ds_over_in == 6'h00) ? 8'h00 : run_r + {7'h0, run_r != 8'hff};
   end
   AST_DS_TH: assert property (wr_p |=> drain_source_threshold_code_out == $past(reg_wdata_in[9:6]))
      else $error("threshold code not taken from write");
   AST_SH_TH: assert property (wr_s |=> shunt_overcurrent_threshold_out == $past(reg_wdata_in[11:9]))
      else $error("shunt threshold not taken from write");
   AST_CAL_ROUTE: assert property (cal_c_start_out || cal_bemf_start_out |->
      cal_c_start_out == !back_emf_sense_enable_out) else $error("calibration routed wrongly");
   AST_CAL_A_CLEAR: assert property (cal_a_start_out && cal_a_done_in && !wr_s |=> !cal_a_start_out)
      else $error("calibration bit did not clear");
   AST_DEGLITCH: assert property ($rose(ds_f) |-> run_r >= 8'h38)
      else $error("flag set before deglitch time");
   AST_PIN_REPORT: assert property (act |-> !fault_output_pin_n_out)
      else $error("fault pin not driven");
   AST_PIN_IGNORE: assert property (!fault_output_pin_n_out |-> act)
      else $error("fault pin driven without cause");
   AST_GATE_CAUSE: assert property ($rose(gate_disable_out) |->
      (ds_f && !mode_r[3]) || (sh_f && !mode_r[1])) else $error("gates disabled without cause");
   AST_CLEAR_CMD: assert property ((ds_over_in == 6'h00)[*3] ##0
      (reg_wr_in && reg_addr_in == ocfr_pkg::ADDR_CTRL1 && reg_wdata_in[11]) |=> !ds_f)
      else $error("clear command left flag set");
   cover property ($rose(gate_disable_out));
   cover property (cal_bemf_start_out);
   cover property (ds_f && fault_output_pin_n_out);
endmodule
bind ocfr_top ocfr_chk i_ocfr_chk (.mclk_in, .nrst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .ds_over_in,
   .cal_a_done_in, .drain_source_threshold_code_out, .shunt_overcurrent_threshold_out,
   .back_emf_sense_enable_out, .cal_a_start_out, .cal_c_start_out, .cal_bemf_start_out,
   .drain_source_overcurrent_flag_out, .shunt_overcurrent_flag_out, .fault_output_pin_n_out, .gate_disable_out);
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the overcurrent response and sense configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {logic [3:0] a; logic [11:0] d; logic [11:0] q;} ocfr_row_type;
   ocfr_row_type rows [6] = '{'{4'h3, 12'hfff, 12'hfff}, '{4'h3, 12'h5a5, 12'h5a5}, '{4'h4, 12'hf8f, 12'hf8f},
                            '{4'h4, 12'h000, 12'h000}, '{4'h2, 12'h800, 12'h000}, '{4'h7, 12'h123, 12'h000}};
   logic        mclk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, enable_pin_in = 1'b1, sel_ds = 1'b0;
   logic [3:0]  reg_addr_in = 4'h0;
   wire logic [3:0] cal_start, cal_done;
   wire logic [2:0] sh_th;
   wire logic [1:0] cs_gain, back_emf_gain;
   wire logic       back_emf_sense_enable, amp_c, common_pin;
   logic [11:0] reg_wdata_in = 12'h000, reg_rdata_out;
   logic [5:0]  ds_over_in = 6'h00;
   logic [2:0]  shunt_over_in = 3'h0;
   logic        ds_flag, sh_flag, fault_output_pin_n_out, gate_disable_out;
   wire logic   flag_sel = sel_ds ? ds_flag : sh_flag;
   int          n_mismatch = 0, tests_run = 0, cyc = 0, k = 0;
   ocfr_top i_ocfr_top (.mclk_in, .nrst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
      .enable_pin_in, .ds_over_in, .shunt_over_in, .cal_a_done_in(cal_done[0]), .cal_b_done_in(cal_done[1]),
      .cal_c_done_in(cal_done[2]), .cal_bemf_done_in(cal_done[3]), .drain_source_threshold_code_out(),
      .shunt_overcurrent_threshold_out(sh_th), .cs_gain_out(cs_gain), .back_emf_gain_out(back_emf_gain),
      .back_emf_sense_enable_out(back_emf_sense_enable), .amp_c_for_bemf_out(amp_c), .use_common_pin_out(common_pin),
      .cal_a_start_out(cal_start[0]), .cal_b_start_out(cal_start[1]),
      .cal_c_start_out(cal_start[2]), .cal_bemf_start_out(cal_start[3]), .drain_source_overcurrent_flag_out(ds_flag),
      .shunt_overcurrent_flag_out(sh_flag), .fault_output_pin_n_out, .gate_disable_out);
   ocfr_afe_model i_ocfr_afe_model (.mclk_in, .start_in(cal_start), .done_out(cal_done));
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // An idle cycle between writes keeps the strobe a clean pulse
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      @(negedge mclk_in);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge mclk_in);
      reg_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [11:0] exp);
      @(negedge mclk_in);
      reg_addr_in = a;
      @(negedge mclk_in);
      chk($sformatf("reg %0h", a), exp, reg_rdata_out);
   endtask
   task automatic wait_lvl(input logic gate, input logic lvl, input int lim);
      k = 0;
      while ((gate ? gate_disable_out : flag_sel) !== lvl && k < lim) begin
         @(negedge mclk_in);
         k++;
      end
   endtask
   task automatic fault_case(input logic ds, input logic [1:0] m, input logic by_clr);
      sel_ds = ds;
      wr(ocfr_pkg::ADDR_PROT, {ds ? m : 2'h3, 6'h25, 2'h3, ds ? 2'h3 : m});
      ds_over_in = ds ? 6'h04 : 6'h00;
      shunt_over_in = ds ? 3'h0 : 3'h2;
      wait_lvl(1'b0, 1'b1, 300);
      chk("deglitch", 12'h001, {11'h0, k >= ocfr_pkg::DEG1_CYC});
      chk("flag", 12'h001, {11'h0, flag_sel});
      chk("fault pin", {11'h0, m == 2'h3}, {11'h0, fault_output_pin_n_out});
      chk("gate disable", {11'h0, m < 2'h2}, {11'h0, gate_disable_out});
      ds_over_in = 6'h00;
      shunt_over_in = 3'h0;
      wait_lvl(1'b1, 1'b0, m == 2'h1 ? 3200 : 6);
      chk("retry", {11'h0, m != 2'h0}, {11'h0, m == 2'h1 ? k >= ocfr_pkg::RETRY_SHORT_CYC && k < 3200
         : !gate_disable_out});
      if (by_clr)
         wr(ocfr_pkg::ADDR_CTRL1, 12'h800);
      else
         enable_pin_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      enable_pin_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      chk("released", 12'h001, {9'h0, flag_sel, gate_disable_out, fault_output_pin_n_out});
   endtask
   initial begin
      repeat (2) @(negedge mclk_in);
      nrst_in = 1'b1;
      rd(ocfr_pkg::ADDR_PROT, ocfr_pkg::PROT_RESET);
      rd(ocfr_pkg::ADDR_SENSE, ocfr_pkg::SENSE_RESET);
      chk("idle", 12'h001, {9'h0, ds_flag, gate_disable_out, fault_output_pin_n_out});
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].q);
      end
      nrst_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      nrst_in = 1'b1;
      rd(ocfr_pkg::ADDR_PROT, ocfr_pkg::PROT_RESET);
      wr(ocfr_pkg::ADDR_SENSE, ocfr_pkg::SENSE_RESET | 12'h070);
      chk("cal starts", 12'h007, {8'h0, cal_start});
      repeat (30) @(negedge mclk_in);
      rd(ocfr_pkg::ADDR_SENSE, ocfr_pkg::SENSE_RESET);
      wr(ocfr_pkg::ADDR_SENSE, 12'ha9b);
      chk("bemf cal start", 12'h008, {8'h0, cal_start});
      chk("config", 12'haec, {sh_th, cs_gain, back_emf_sense_enable, amp_c, back_emf_gain, common_pin, 2'h0});
      repeat (30) @(negedge mclk_in);
      rd(ocfr_pkg::ADDR_SENSE, 12'ha8b);
      for (int i = 0; i < 8; i++) begin
         fault_case(i[2], i[1:0], i[0] ^ i[2]);
      end
      finish_test();
   end
endmodule
`default_nettype wire

/* verilog/ocfr_deglitch.sv */
// Filter that passes a condition once it has persisted for a programmed cycle count
`timescale 1ns/1ps
`default_nettype none
module ocfr_deglitch (
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic        cond_in,
   input  wire logic [7:0]  count_in,
   output logic             qual_out
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       qual_r;
   logic       reached;

   assign reached  = cond_in && (cnt_r >= count_in - 8'h01);
   assign cnt_nxt  = !cond_in ? 8'h00 : (reached ? cnt_r : cnt_r + 8'h01);
   assign qual_out = qual_r;

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         cnt_r  <= 8'h00;
         qual_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         qual_r <= reached;
      end
   end
endmodule
`default_nettype wire

/* verilog/ocfr_pkg.sv */
// Package: register map, field positions, reset values and timing for overcurrent response config
`default_nettype none
package ocfr_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam logic [3:0] ADDR_CTRL1 = 4'h2;
   localparam logic [3:0] ADDR_PROT  = 4'h3;
   localparam logic [3:0] ADDR_SENSE = 4'h4;
   localparam int unsigned CTRL1_CLR_BIT = 11;
   // protection_response_config fields
   localparam int unsigned DS_MODE_LSB  = 10;
   localparam int unsigned DS_TH_LSB    = 6;
   localparam int unsigned DEG_LSB      = 4;
   localparam int unsigned DS_RETRY_BIT = 3;
   localparam int unsigned SH_RETRY_BIT = 2;
   localparam int unsigned SH_MODE_LSB  = 0;
   localparam logic [11:0] PROT_RESET = 12'h250;
   // sense_amplifier_config fields
   localparam int unsigned SH_TH_LSB    = 9;
   localparam int unsigned CS_GAIN_LSB  = 7;
   localparam int unsigned CAL_A_BIT    = 6;
   localparam int unsigned CAL_B_BIT    = 5;
   localparam int unsigned CAL_C_BIT    = 4;
   localparam int unsigned BACK_EMF_SENSE_ENABLE_BIT  = 3;
   localparam int unsigned BEMF_G_LSB   = 1;
   localparam int unsigned COMMON_BIT   = 0;
   localparam logic [11:0] SENSE_RESET  = 12'hb02;
   localparam logic [11:0] SENSE_SELFCLR = 12'h070;
   // Response modes
   localparam logic [1:0] MODE_LATCH  = 2'h0;
   localparam logic [1:0] MODE_RETRY  = 2'h1;
   localparam logic [1:0] MODE_REPORT = 2'h2;
   localparam logic [1:0] MODE_IGNORE = 2'h3;
   // Times in ns
   localparam int unsigned DEG0_NS = 1400;
   localparam int unsigned DEG1_NS = 2200;
   localparam int unsigned DEG2_NS = 3200;
   localparam int unsigned DEG3_NS = 5400;
   localparam int unsigned RETRY_LONG_NS  = 4_000_000;
   localparam int unsigned RETRY_SHORT_NS = 70_000;
   localparam int unsigned NS_PER_S = 1_000_000_000;
   localparam int unsigned CPNS = NS_PER_S / CLK_HZ;
   // Least times round up
   localparam int unsigned DEG0_CYC = (DEG0_NS + CPNS - 1) / CPNS;
   localparam int unsigned DEG1_CYC = (DEG1_NS + CPNS - 1) / CPNS;
   localparam int unsigned DEG2_CYC = (DEG2_NS + CPNS - 1) / CPNS;
   localparam int unsigned DEG3_CYC = (DEG3_NS + CPNS - 1) / CPNS;
   localparam int unsigned RETRY_LONG_CYC  = (RETRY_LONG_NS + CPNS - 1) / CPNS;
   localparam int unsigned RETRY_SHORT_CYC = (RETRY_SHORT_NS + CPNS - 1) / CPNS;
   localparam int unsigned CNT_W = 18;
endpackage
`default_nettype wire

/* verilog/ocfr_response.sv */
// Per-fault response engine: latch, timed retry, report only or ignore
`timescale 1ns/1ps
`default_nettype none
module ocfr_response (
   input  wire logic                      mclk_in,
   input  wire logic                      nrst_in,
   input  wire logic                      fault_in,
   input  wire logic [1:0]                mode_in,
   input  wire logic                      short_delay_in,
   input  wire logic                      release_in,
   output logic                           flag_out,
   output logic                           report_out,
   output logic                           shutdown_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_LATCHED, ST_WAIT} ocfr_rsp_type;
   ocfr_rsp_type st_r;
   ocfr_rsp_type st_nxt;
   logic [ocfr_pkg::CNT_W-1:0] cnt_r;
   logic [ocfr_pkg::CNT_W-1:0] cnt_nxt;
   logic [ocfr_pkg::CNT_W-1:0] delay;
   logic flag_r;
   logic flag_nxt;
   logic protect;

   assign delay = short_delay_in ? ocfr_pkg::CNT_W'(ocfr_pkg::RETRY_SHORT_CYC)
                                 : ocfr_pkg::CNT_W'(ocfr_pkg::RETRY_LONG_CYC);
   assign protect = (mode_in == ocfr_pkg::MODE_LATCH) || (mode_in == ocfr_pkg::MODE_RETRY);
   // Set wins over clear so a fault in the clear cycle survives
   assign flag_nxt = fault_in ? 1'b1 : (release_in ? 1'b0 : flag_r);

   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         ST_IDLE: begin
            if (fault_in && mode_in == ocfr_pkg::MODE_LATCH) begin
               st_nxt = ST_LATCHED;
            end else if (fault_in && mode_in == ocfr_pkg::MODE_RETRY) begin
               st_nxt  = ST_WAIT;
               cnt_nxt = '0;
            end
         end
         ST_LATCHED: begin
            if (release_in && !fault_in) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (fault_in) begin
               cnt_nxt = '0;
            end else if (cnt_r >= delay - ocfr_pkg::CNT_W'(1)) begin
               st_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r + ocfr_pkg::CNT_W'(1);
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   assign flag_out     = flag_r;
   assign shutdown_out = (st_r != ST_IDLE);
   assign report_out   = flag_r && (mode_in != ocfr_pkg::MODE_IGNORE);

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         st_r   <= ST_IDLE;
         cnt_r  <= '0;
         flag_r <= 1'b0;
      end else begin
         st_r   <= protect || st_r != ST_IDLE ? st_nxt : ST_IDLE;
         cnt_r  <= cnt_nxt;
         flag_r <= flag_nxt;
      end
   end
endmodule
`default_nettype wire

/* verilog/ocfr_top.sv */
// Overcurrent fault response and sense amplifier configuration registers
`timescale 1ns/1ps
`default_nettype none
module ocfr_top (
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic        reg_wr_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [11:0] reg_wdata_in,
   output logic [11:0]      reg_rdata_out,
   input  wire logic        enable_pin_in,
   input  wire logic [5:0]  ds_over_in,
   input  wire logic [2:0]  shunt_over_in,
   input  wire logic        cal_a_done_in,
   input  wire logic        cal_b_done_in,
   input  wire logic        cal_c_done_in,
   input  wire logic        cal_bemf_done_in,
   output logic [3:0]       drain_source_threshold_code_out,
   output logic [2:0]       shunt_overcurrent_threshold_out,
   output logic [1:0]       cs_gain_out,
   output logic [1:0]       back_emf_gain_out,
   output logic             back_emf_sense_enable_out,
   output logic             amp_c_for_bemf_out,
   output logic             use_common_pin_out,
   output logic             cal_a_start_out,
   output logic             cal_b_start_out,
   output logic             cal_c_start_out,
   output logic             cal_bemf_start_out,
   output logic             drain_source_overcurrent_flag_out,
   output logic             shunt_overcurrent_flag_out,
   output logic             fault_output_pin_n_out,
   output logic             gate_disable_out
);
   logic [11:0] prot_r;
   logic [11:0] sense_r;
   logic [11:0] sense_nxt;
   logic [11:0] rdata_r;
   logic [11:0] rdata_nxt;
   logic        en_d_r;
   logic        wr_prot;
   logic        wr_sense;
   logic        clr_cmd;
   logic        en_release;
   logic        release_all;
   logic [1:0]  ds_mode;
   logic [1:0]  sh_mode;
   logic [1:0]  deg_sel;
   logic [7:0]  deg_cnt;
   logic        ds_raw;
   logic        sh_raw;
   logic        ds_qual;
   logic        sh_qual;
   logic        ds_report;
   logic        sh_report;
   logic        ds_shut;
   logic        sh_shut;
   logic        cal_c_route;
   logic        cal_c_done;
   logic [11:0] cal_done_mask;

   function automatic logic [7:0] deg_cycles(input logic [1:0] sel);
      case (sel)
         2'h0:    deg_cycles = 8'(ocfr_pkg::DEG0_CYC);
         2'h1:    deg_cycles = 8'(ocfr_pkg::DEG1_CYC);
         2'h2:    deg_cycles = 8'(ocfr_pkg::DEG2_CYC);
         default: deg_cycles = 8'(ocfr_pkg::DEG3_CYC);
      endcase
   endfunction

   assign wr_prot  = reg_wr_in && (reg_addr_in == ocfr_pkg::ADDR_PROT);
   assign wr_sense = reg_wr_in && (reg_addr_in == ocfr_pkg::ADDR_SENSE);
   assign clr_cmd  = reg_wr_in && (reg_addr_in == ocfr_pkg::ADDR_CTRL1)
                     && reg_wdata_in[ocfr_pkg::CTRL1_CLR_BIT];
   // Rising enable ends a recovery low pulse
   assign en_release  = enable_pin_in && !en_d_r;
   assign release_all = clr_cmd || en_release;

   assign ds_mode = prot_r[ocfr_pkg::DS_MODE_LSB +: 2];
   assign sh_mode = prot_r[ocfr_pkg::SH_MODE_LSB +: 2];
   assign deg_sel = prot_r[ocfr_pkg::DEG_LSB +: 2];
   assign deg_cnt = deg_cycles(deg_sel);
   assign ds_raw  = |ds_over_in;
   assign sh_raw  = |shunt_over_in;

   assign drain_source_threshold_code_out = prot_r[ocfr_pkg::DS_TH_LSB +: 4];
   assign shunt_overcurrent_threshold_out = sense_r[ocfr_pkg::SH_TH_LSB +: 3];
   assign cs_gain_out       = sense_r[ocfr_pkg::CS_GAIN_LSB +: 2];
   assign back_emf_gain_out = sense_r[ocfr_pkg::BEMF_G_LSB +: 2];
   assign back_emf_sense_enable_out = sense_r[ocfr_pkg::BACK_EMF_SENSE_ENABLE_BIT];
   assign amp_c_for_bemf_out        = sense_r[ocfr_pkg::BACK_EMF_SENSE_ENABLE_BIT];
   assign use_common_pin_out = sense_r[ocfr_pkg::COMMON_BIT];

   assign cal_a_start_out = sense_r[ocfr_pkg::CAL_A_BIT];
   assign cal_b_start_out = sense_r[ocfr_pkg::CAL_B_BIT];
   assign cal_c_route        = sense_r[ocfr_pkg::CAL_C_BIT];
   assign cal_c_start_out    = cal_c_route && !sense_r[ocfr_pkg::BACK_EMF_SENSE_ENABLE_BIT];
   assign cal_bemf_start_out = cal_c_route && sense_r[ocfr_pkg::BACK_EMF_SENSE_ENABLE_BIT];
   assign cal_c_done = sense_r[ocfr_pkg::BACK_EMF_SENSE_ENABLE_BIT] ? cal_bemf_done_in : cal_c_done_in;

   // Completion clears only the bit whose calibration finished
   always_comb begin
      cal_done_mask = 12'h000;
      cal_done_mask[ocfr_pkg::CAL_A_BIT] = cal_a_done_in;
      cal_done_mask[ocfr_pkg::CAL_B_BIT] = cal_b_done_in;
      cal_done_mask[ocfr_pkg::CAL_C_BIT] = cal_c_done;
   end

   // write then self-clear; a new start written in the done cycle wins
   assign sense_nxt = wr_sense ? reg_wdata_in : (sense_r & ~cal_done_mask);

   // readback, fault clear bit reads zero
   always_comb begin
      case (reg_addr_in)
         ocfr_pkg::ADDR_PROT:  rdata_nxt = prot_r;
         ocfr_pkg::ADDR_SENSE: rdata_nxt = sense_r;
         default:              rdata_nxt = 12'h000;
      endcase
   end
   assign reg_rdata_out = rdata_r;

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         prot_r  <= ocfr_pkg::PROT_RESET;
         sense_r <= ocfr_pkg::SENSE_RESET;
         rdata_r <= 12'h000;
         en_d_r  <= 1'b1;
      end else begin
         if (wr_prot) begin
            prot_r <= reg_wdata_in;
         end
         sense_r <= sense_nxt;
         rdata_r <= rdata_nxt;
         en_d_r  <= enable_pin_in;
      end
   end

   ocfr_deglitch u_ds_deg (
      .mclk_in  (mclk_in),
      .nrst_in  (nrst_in),
      .cond_in  (ds_raw),
      .count_in (deg_cnt),
      .qual_out (ds_qual)
   );

   ocfr_deglitch u_sh_deg (
      .mclk_in  (mclk_in),
      .nrst_in  (nrst_in),
      .cond_in  (sh_raw),
      .count_in (deg_cnt),
      .qual_out (sh_qual)
   );

   ocfr_response u_ds_rsp (
      .mclk_in        (mclk_in),
      .nrst_in        (nrst_in),
      .fault_in       (ds_qual),
      .mode_in        (ds_mode),
      .short_delay_in (prot_r[ocfr_pkg::DS_RETRY_BIT]),
      .release_in     (release_all),
      .flag_out       (drain_source_overcurrent_flag_out),
      .report_out     (ds_report),
      .shutdown_out   (ds_shut)
   );

   ocfr_response u_sh_rsp (
      .mclk_in        (mclk_in),
      .nrst_in        (nrst_in),
      .fault_in       (sh_qual),
      .mode_in        (sh_mode),
      .short_delay_in (prot_r[ocfr_pkg::SH_RETRY_BIT]),
      .release_in     (release_all),
      .flag_out       (shunt_overcurrent_flag_out),
      .report_out     (sh_report),
      .shutdown_out   (sh_shut)
   );

   assign gate_disable_out       = ds_shut || sh_shut;
   assign fault_output_pin_n_out = !(ds_report || sh_report);
endmodule
`default_nettype wire
